//--- ldd_pkg.sv
// package: constants and carrier types for the display link deserializer
`default_nettype none
package ldd_pkg;
  // lane and word geometry
  localparam int unsigned LANES_WIDE    = 4;
  localparam int unsigned LANES_NARROW  = 3;
  localparam int unsigned BITS_PER_LANE = 7;
  localparam int unsigned WORD_W        = LANES_WIDE * BITS_PER_LANE;

  // word field positions
  localparam int unsigned RED_HI_LSB   = 0;
  localparam int unsigned GREEN_HI_LSB = 6;
  localparam int unsigned BLUE_HI_LSB  = 12;
  localparam int unsigned LINE_POS     = 18;
  localparam int unsigned FRAME_POS    = 19;
  localparam int unsigned READY_POS    = 20;
  localparam int unsigned RED_LO_LSB   = 21;
  localparam int unsigned GREEN_LO_LSB = 23;
  localparam int unsigned BLUE_LO_LSB  = 25;
  localparam int unsigned CTRL_POS     = 27;

  // timing
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned PD_DELAY_NS       = 1000;
  localparam int unsigned PD_DELAY_CYC      = PD_DELAY_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned LOCK_TIME_MS      = 10;
  localparam int unsigned LOCK_TIME_CYC     = LOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_PERIODS      = 4;
  localparam int unsigned CNT_W             = 8;
  localparam logic [CNT_W-1:0] MIN_PERIOD_CYC = 8'h07;
  localparam logic [CNT_W-1:0] MAX_PERIOD_CYC = 8'h40;

  // reset values
  localparam logic [CNT_W-1:0] PERIOD_RST = 8'h00;
  localparam logic [2:0]       STABLE_RST = 3'h0;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic       line_sync;
    logic       frame_sync;
    logic       data_ready;
    logic       general_control_bit;
  } ldd_pixel_t;

  typedef struct packed {
    logic       link_clock_in;
    logic [3:0] serial_data_lane;
  } ldd_link_t;
endpackage : ldd_pkg
`default_nettype wire

//--- ldd_deserializer.sv
// module: display link deserializer with clock recovery and power-down gating
`default_nettype none
// What this block does
// - wide: four lanes into 28-bit word
// - narrow: three lanes into 21-bit word
// - wide control: hsync, vsync, enable, control
// - wide colour eight bits each plus syncs
// - narrow colour six bits each plus syncs
// - seven samples per lane each link period
// - data captured on shift clock falling edge
// - works with either transmitter launch edge
// - link clock kept within supported range
// - shift clock output has equal halves for even periods
// - power-down low forces data outputs low
// - lock and valid output within 10 ms
// - power-down reaches outputs within 1 us
module ldd_deserializer #(
  parameter bit          WIDE             = 1'b1,
  parameter int unsigned LOCK_TIMEOUT_CYC = ldd_pkg::LOCK_TIME_CYC
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire ldd_pkg::ldd_link_t link_in,
  input  wire logic               power_down_n,
  output var  ldd_pkg::ldd_pixel_t parallel_data_out,
  output var  logic               shift_clock_out,
  output var  logic               pll_locked
);
  import ldd_pkg::*;

  localparam int unsigned LANES = WIDE ? LANES_WIDE : LANES_NARROW;
  localparam int unsigned TMO_W = $clog2(LOCK_TIMEOUT_CYC + 1);

  // two-flop synchronisers for all pins
  ldd_link_t link_m_r;
  ldd_link_t link_s_r;
  logic      pd_m_r;
  logic      pd_s_r;
  logic      clk_prev_r;
  logic      edge_rise;

  always_ff @(posedge clock) begin
    if (rst) begin
      link_m_r <= '0;
      link_s_r <= '0;
    end else if (ce) begin
      link_m_r <= link_in;
      link_s_r <= link_m_r;
    end
  end

  // power-down resets to asserted so nothing leaks out before the sync fills
  always_ff @(posedge clock) begin
    if (rst) begin
      pd_m_r <= 1'b0;
      pd_s_r <= 1'b0;
    end else if (ce) begin
      pd_m_r <= power_down_n;
      pd_s_r <= pd_m_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clk_prev_r <= 1'b0;
    end else if (ce) begin
      clk_prev_r <= link_s_r.link_clock_in;
    end
  end

  // lanes and clock share the sync delay, so their phase relation is kept
  assign edge_rise = link_s_r.link_clock_in & ~clk_prev_r;

  // period measurement: the recovery loop
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] period_r;
  logic [2:0]       stable_r;
  logic             locked_r;
  logic [TMO_W-1:0] tmo_r;
  logic             period_ok;
  logic             period_same;

  assign period_ok   = (cnt_r + 8'h01 >= MIN_PERIOD_CYC) && (cnt_r + 8'h01 <= MAX_PERIOD_CYC);
  assign period_same = (cnt_r + 8'h01 == period_r) || (cnt_r == period_r) ||
                       (cnt_r + 8'h02 == period_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= PERIOD_RST;
    end else if (ce) begin
      if (edge_rise) begin
        cnt_r <= PERIOD_RST;
      end else if (cnt_r != MAX_PERIOD_CYC) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      period_r <= PERIOD_RST;
    end else if (ce && edge_rise) begin
      period_r <= cnt_r + 8'h01;
    end
  end

  // lock after a run of matching periods; drop on a stalled or odd clock
  typedef enum logic [0:0] {LK_SEARCH, LK_TRACK} ldd_lock_t;
  ldd_lock_t lock_state_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      stable_r     <= STABLE_RST;
      lock_state_r <= LK_SEARCH;
    end else if (ce) begin
      unique case (lock_state_r)
        LK_SEARCH: begin
          if (cnt_r == MAX_PERIOD_CYC) begin
            stable_r <= STABLE_RST;
          end else if (edge_rise) begin
            if (!period_ok || !period_same) begin
              stable_r <= STABLE_RST;
            end else if (stable_r == 3'(LOCK_PERIODS)) begin
              lock_state_r <= LK_TRACK;
            end else begin
              stable_r <= stable_r + 3'h1;
            end
          end else if (tmo_r == TMO_W'(LOCK_TIMEOUT_CYC)) begin
            stable_r <= STABLE_RST;
          end
        end
        LK_TRACK: begin
          // a stall or a period jump leaves the sample grid meaningless
          if (cnt_r == MAX_PERIOD_CYC || (edge_rise && (!period_ok || !period_same))) begin
            stable_r     <= STABLE_RST;
            lock_state_r <= LK_SEARCH;
          end
        end
      endcase
    end
  end

  assign locked_r = lock_state_r == LK_TRACK;

  // acquisition watchdog restarts the search if lock is overdue
  always_ff @(posedge clock) begin
    if (rst) begin
      tmo_r <= '0;
    end else if (ce) begin
      if (locked_r || tmo_r == TMO_W'(LOCK_TIMEOUT_CYC)) begin
        tmo_r <= '0;
      end else begin
        tmo_r <= tmo_r + 1'b1;
      end
    end
  end

  // sample point generator: seven strobes spread over the measured period
  logic [CNT_W:0] acc_r;
  logic [CNT_W:0] acc_sum;
  logic           strobe;
  logic [2:0]     bit_idx_r;
  logic [2:0]     sample_idx;

  // bit b is taken in the first cycle j of the period with 7*j >= b*P;
  // acc_r holds 7*j - b*P + P so the test needs no sign
  assign acc_sum    = acc_r + (CNT_W+1)'(BITS_PER_LANE);
  assign strobe     = edge_rise ||
                      ((bit_idx_r != 3'(BITS_PER_LANE)) && (acc_r >= {1'b0, period_r}));
  assign sample_idx = edge_rise ? 3'h0 : bit_idx_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_r     <= '0;
      bit_idx_r <= 3'h0;
    end else if (ce) begin
      if (edge_rise) begin
        // bit 0 is taken in the edge cycle itself, before the pin moves on
        acc_r     <= (CNT_W+1)'(BITS_PER_LANE);
        bit_idx_r <= 3'h1;
      end else if (strobe) begin
        acc_r     <= acc_sum - {1'b0, period_r};
        bit_idx_r <= bit_idx_r + 3'h1;
      end else if (bit_idx_r != 3'(BITS_PER_LANE)) begin
        // frozen once the word is full, so a long period cannot wrap it
        acc_r <= acc_sum;
      end
    end
  end

  // per-lane shift registers, bit 0 first in the period
  logic [BITS_PER_LANE-1:0] lane_sh_r [LANES_WIDE];
  logic [WORD_W-1:0]        word;

  genvar g;
  generate
    for (g = 0; g < LANES_WIDE; g++) begin : g_lane
      ldd_lane_shift #(
        .BITS (BITS_PER_LANE)
      ) u_lane (
        .clock    (clock),
        .rst      (rst),
        .ce       (ce),
        .enable   (g < LANES),
        .strobe   (strobe),
        .bit_idx  (sample_idx),
        .lane_bit (link_s_r.serial_data_lane[g]),
        .bits     (lane_sh_r[g])
      );
      assign word[g*BITS_PER_LANE +: BITS_PER_LANE] = lane_sh_r[g];
    end
  endgenerate

  // word to pixel fields; narrow parts leave low colour bits and control at zero
  ldd_pixel_t pix;

  always_comb begin
    pix = '0;
    pix.red[7:2]   = word[RED_HI_LSB +: 6];
    pix.green[7:2] = word[GREEN_HI_LSB +: 6];
    pix.blue[7:2]  = word[BLUE_HI_LSB +: 6];
    pix.line_sync  = word[LINE_POS];
    pix.frame_sync = word[FRAME_POS];
    pix.data_ready = word[READY_POS];
    if (WIDE) begin
      pix.red[1:0]            = word[RED_LO_LSB +: 2];
      pix.green[1:0]          = word[GREEN_LO_LSB +: 2];
      pix.blue[1:0]           = word[BLUE_LO_LSB +: 2];
      pix.general_control_bit = word[CTRL_POS];
    end
  end

  // output stage: word launched as shift clock rises, held a full period
  logic word_done;
  logic out_enable;

  assign word_done  = bit_idx_r == 3'(BITS_PER_LANE);
  // sync path is 3 cycles, far inside the power-down limit
  assign out_enable = pd_s_r && locked_r;

  ldd_pixel_t data_nxt;
  logic       shift_nxt;

  always_comb begin
    data_nxt = parallel_data_out;
    if (!out_enable) begin
      data_nxt = '0;
    end else if (edge_rise && word_done) begin
      data_nxt = pix;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      parallel_data_out <= '0;
    end else if (ce) begin
      parallel_data_out <= data_nxt;
    end
  end

  // regenerated shift clock: high first half, low second half
  always_comb begin
    shift_nxt = shift_clock_out;
    if (!out_enable) begin
      shift_nxt = 1'b0;
    end else if (edge_rise) begin
      shift_nxt = 1'b1;
    end else if (cnt_r + 8'h02 > (period_r >> 1)) begin
      // odd periods give at most one cycle of imbalance
      shift_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_clock_out <= 1'b0;
    end else if (ce) begin
      shift_clock_out <= shift_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pll_locked <= 1'b0;
    end else if (ce) begin
      pll_locked <= locked_r;
    end
  end
endmodule : ldd_deserializer

// one lane: seven sampled bits written by index as the strobes arrive
module ldd_lane_shift #(
  parameter int unsigned BITS = 7
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    enable,
  input  wire logic                    strobe,
  input  wire logic [$clog2(BITS)-1:0] bit_idx,
  input  wire logic                    lane_bit,
  output var  logic [BITS-1:0]         bits
);
  import ldd_pkg::*;

  // an unused lane stays at zero so its fields read as cleared
  always_ff @(posedge clock) begin
    if (rst) begin
      bits <= '0;
    end else if (ce && enable && strobe) begin
      bits[bit_idx] <= lane_bit;
    end
  end
endmodule : ldd_lane_shift
`default_nettype wire

//--- ldd_sva.sv
// checker: deserializer port properties
`default_nettype none
module ldd_sva #(parameter bit WIDE = 1'b1) (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_down_n,
  input wire ldd_pkg::ldd_pixel_t parallel_data_out,
  input wire logic shift_clock_out,
  input wire logic pll_locked
);
  import ldd_pkg::*;
  localparam int PD_CYC = PD_DELAY_CYC;
  ldd_pixel_t d;
  logic scl;
  assign d = parallel_data_out;
  assign scl = shift_clock_out;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // high phase at least two cycles, fall within the longest half period
  sequence s_high; scl [*2]; endsequence
  sequence s_fall; ##[0:31] !scl; endsequence
  a_pd_low: assert property (!power_down_n [*6] |-> d == '0) else $error("pd data");
  a_pd_clk: assert property (!power_down_n [*6] |-> !scl) else $error("pd clock");
  a_pd_delay: assert property ($fell(power_down_n) |-> ##[1:PD_CYC] d == '0)
    else $error("pd slow");
  a_unlock_low: assert property (!pll_locked && !$past(pll_locked) |-> d == '0)
    else $error("unlocked data");
  // release of power-down is excluded: forced data may reappear off edge
  a_word_edge: assert property ($changed(d) && pll_locked && $past(pll_locked)
    && power_down_n && $past(power_down_n, 6) |-> $rose(scl)) else $error("word off edge");
  a_narrow_zero: assert property (!WIDE |-> {d[21:20], d[13:12], d[5:4], d[0]} == 7'h00)
    else $error("narrow bits");
  a_rise_lock: assert property ($rose(scl) |-> ##[0:1] pll_locked)
    else $error("scl unlocked");
  a_halves: assert property ($rose(scl) |-> s_high ##0 s_fall) else $error("scl phase");
endmodule : ldd_sva
bind ldd_deserializer ldd_sva #(.WIDE(WIDE)) u_sva (.clock(clock), .rst(rst),
  .power_down_n(power_down_n), .parallel_data_out(parallel_data_out),
  .shift_clock_out(shift_clock_out), .pll_locked(pll_locked));
`default_nettype wire

//--- ldd_tx_model.sv
// model: serializing transmitter forwarding the link clock
`default_nettype none
module ldd_tx_model #(parameter real PERIOD_NS = 200.0) (
  input wire logic run,
  input wire logic [27:0] word,
  output var ldd_pkg::ldd_link_t link
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldd_pkg::*;
  logic [27:0] w_r;
  logic r_r;
  initial begin
    link = '0;
    #7.3;
    forever begin
      w_r = word;
      r_r = run;
      for (int i = 0; i < 7; i++) begin
        link.link_clock_in = r_r && i < 4; // stands still while idle
        for (int k = 0; k < 4; k++)
          link.serial_data_lane[k] = r_r ? w_r[7*k+i] : ~link.serial_data_lane[k];
        #(PERIOD_NS / 7.0);
      end
    end
  end
endmodule : ldd_tx_model
`default_nettype wire

//--- tb.sv
// testbench: transmitter model into wide and narrow deserializers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ldd_pkg::*;
  localparam logic [27:0] PAT [7] = '{28'h0040000, 28'h0080000, 28'h0100000,
    28'h8000000, 28'h5555555, 28'hAAAAAAA, 28'hFFFFFFF};
  logic clock = 1'b0, rst = 1'b1, pd_n = 1'b1, run = 1'b0, scl, lk, lkn;
  logic [27:0] word = 28'h0000000;
  ldd_link_t link;
  ldd_pixel_t px, pxn;
  int err_count = 0, checked = 0, cyc = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  ldd_tx_model u_tx (.run(run), .word(word), .link(link));
  ldd_deserializer #(.LOCK_TIMEOUT_CYC(2000)) u_dut (.clock(clock), .rst(rst), .ce(1'b1),
    .link_in(link), .power_down_n(pd_n), .parallel_data_out(px), .shift_clock_out(scl),
    .pll_locked(lk));
  ldd_deserializer #(.WIDE(1'b0), .LOCK_TIMEOUT_CYC(2000)) u_nar (.clock(clock), .rst(rst),
    .ce(1'b1), .link_in(link), .power_down_n(pd_n), .parallel_data_out(pxn),
    .shift_clock_out(), .pll_locked(lkn));
  task automatic check(string s, logic [27:0] e, logic [27:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : check
  function automatic ldd_pixel_t to_px(logic [27:0] w);
    return {w[5:0], w[22:21], w[11:6], w[24:23], w[17:12], w[26:25], w[18], w[19], w[20], w[27]};
  endfunction : to_px
  // k falls of the shift clock; a word is only safe to read there
  task automatic strobe(int k);
    int n;
    repeat (k) begin
      n = 0;
      while (scl !== 1'b1 && n++ < 99) @(negedge clock);
      while (scl !== 1'b0 && n++ < 99) @(negedge clock);
    end
  endtask : strobe
  task automatic t_lock;
    int n = 0;
    check("reset data", 28'h0, px);
    @(posedge clock) run <= 1'b1;
    while (lk !== 1'b1 && n++ < 400) @(negedge clock);
    check("lock", 28'h1, 28'({lkn, lk} == 2'h3));
  endtask : t_lock
  task automatic t_words;
    foreach (PAT[i]) begin
      @(posedge clock) word <= PAT[i];
      strobe(3);
      check("wide word", to_px(PAT[i]), px);
      check("narrow word", to_px(PAT[i] & 28'h01FFFFF), pxn);
    end
  endtask : t_words
  task automatic t_pd;
    int n = 0;
    @(posedge clock) pd_n <= 1'b0;
    @(negedge clock);
    while ((px !== 28'h0 || scl !== 1'b0) && n++ < 99) @(negedge clock);
    check("pd delay", 28'h1, 28'(n <= PD_DELAY_CYC));
    repeat (20) @(negedge clock);
    check("pd data", 28'h0, px | pxn);
    @(posedge clock) pd_n <= 1'b1;
    strobe(3);
    check("pd resume", to_px(word), px);
  endtask : t_pd
  task automatic t_stall;
    @(posedge clock) run <= 1'b0;
    repeat (100) @(negedge clock);
    check("stall", 28'h0, 28'({lk, lkn}) | px);
  endtask : t_stall
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_lock();
    t_words();
    t_pd();
    t_stall();
    finish_test();
  end
endmodule : tb
`default_nettype wire
